// >>> verilog/dbst_map.vh
`ifndef DBST_MAP_VH
`define DBST_MAP_VH

// ----------------------------------------
// instruction codes
// ----------------------------------------
`define DBST_IR_BYPASS0  8'h00
`define DBST_IR_PRELOAD  8'h01
`define DBST_IR_IDCODE   8'h02
`define DBST_IR_CLAMP    8'h04
`define DBST_IR_HIGHZ    8'h08
`define DBST_IR_EXTEST   8'h10
`define DBST_IR_TEMP     8'h20
`define DBST_IR_BYPASS1  8'hff
`define DBST_IR_CAPTURE  8'h01

// ----------------------------------------
// register lengths and cell positions
// ----------------------------------------
`define DBST_IR_LEN      8
`define DBST_BS_LEN      48
`define DBST_ID_LEN      32
`define DBST_TEMP_LEN    8
`define DBST_OE_LOW_BIT  15
`define DBST_OE_HIGH_BIT 32
`define DBST_VREF_BIT    0
`define DBST_RESET_BIT   1
`define DBST_CKC_BIT     45
`define DBST_CKT_BIT     46

// ----------------------------------------
// data register kinds, fifo depth
// ----------------------------------------
`define DBST_KIND_BYP    2'h0
`define DBST_KIND_BS     2'h1
`define DBST_KIND_ID     2'h2
`define DBST_KIND_TEMP   2'h3
`define DBST_FIFO_DEPTH  8

`endif

// >>> verilog/dbst_fifo.v
module dbst_fifo #(
	parameter WIDTH = 96,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// clock and reset
	input  wire             core_clk,
	input  wire             reset_n,
	// filling side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// draining side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	reg             out_valid_reg;
	reg [WIDTH-1:0] out_data_reg;
	wire            push;
	wire            pop;

	assign in_ready  = (count_reg != DEPTH[AW:0]);
	assign push      = in_valid && in_ready;
	// move a word into the output register when it is free
	assign pop       = (count_reg != {(AW+1){1'b0}}) &&
	                   (!out_valid_reg || out_ready);
	assign out_valid = out_valid_reg;
	assign out_data  = out_data_reg;

	always @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always @(posedge core_clk) begin
		if (!reset_n) begin
			wr_ptr_reg    <= {AW{1'b0}};
			rd_ptr_reg    <= {AW{1'b0}};
			count_reg     <= {(AW+1){1'b0}};
			out_valid_reg <= 1'b0;
			out_data_reg  <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg    <= rd_ptr_reg + 1'b1;
				out_data_reg  <= mem[rd_ptr_reg];
				out_valid_reg <= 1'b1;
			end else if (out_ready) begin
				out_valid_reg <= 1'b0;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule // dbst_fifo

// >>> verilog/dbst_tap.v
`include "dbst_map.vh"

module dbst_tap #(
	// arbitrary value, bit 0 must stay set
	parameter [31:0] ID_CODE = 32'h10000001
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        reset_n,
	// test port pins
	input  wire        tck_in,
	input  wire        tms_in,
	input  wire        tdi_in,
	output wire        tdo_out,
	output wire        tdo_oe,
	// pin levels seen by the cells
	input  wire [47:0] pins_in_a,
	input  wire [47:0] pins_in_b,
	// temperature readout
	input  wire [7:0]  temp_code,
	// pattern delivery to the pad ring
	input  wire        pins_ready,
	output wire [47:0] scan_pattern_a,
	output wire [47:0] scan_pattern_b,
	output wire        scan_own_a,
	output wire        scan_own_b,
	output wire        scan_low_oe_a,
	output wire        scan_low_oe_b,
	output wire        scan_high_oe_a,
	output wire        scan_high_oe_b,
	// channel control
	output wire        chan_reset_a,
	output wire        chan_reset_b
);

	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	localparam [15:0] S_TLR  = 16'h0001;
	localparam [15:0] S_RTI  = 16'h0002;
	localparam [15:0] S_SDS  = 16'h0004;
	localparam [15:0] S_CDR  = 16'h0008;
	localparam [15:0] S_SHDR = 16'h0010;
	localparam [15:0] S_E1DR = 16'h0020;
	localparam [15:0] S_PDR  = 16'h0040;
	localparam [15:0] S_E2DR = 16'h0080;
	localparam [15:0] S_UDR  = 16'h0100;
	localparam [15:0] S_SIS  = 16'h0200;
	localparam [15:0] S_CIR  = 16'h0400;
	localparam [15:0] S_SHIR = 16'h0800;
	localparam [15:0] S_E1IR = 16'h1000;
	localparam [15:0] S_PIR  = 16'h2000;
	localparam [15:0] S_E2IR = 16'h4000;
	localparam [15:0] S_UIR  = 16'h8000;

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	function [1:0] dr_kind;
		input [7:0] ir;
		begin
			case (ir)
			`DBST_IR_PRELOAD: dr_kind = `DBST_KIND_BS;
			`DBST_IR_EXTEST:  dr_kind = `DBST_KIND_BS;
			`DBST_IR_IDCODE:  dr_kind = `DBST_KIND_ID;
			`DBST_IR_TEMP:    dr_kind = `DBST_KIND_TEMP;
			// bypass, clamp, high-z and undefined codes
			default:          dr_kind = `DBST_KIND_BYP;
			endcase
		end
	endfunction

	function restrictive;
		input [7:0] ir;
		begin
			restrictive = (ir == `DBST_IR_EXTEST) ||
			              (ir == `DBST_IR_CLAMP)  ||
			              (ir == `DBST_IR_HIGHZ);
		end
	endfunction

	// new data enters at the top of the selected length
	function [47:0] dr_shift;
		input [47:0] v;
		input        si;
		input [1:0]  kind;
		begin
			case (kind)
			`DBST_KIND_BS:   dr_shift = {si, v[47:1]};
			`DBST_KIND_ID:   dr_shift = {16'h0000, si, v[31:1]};
			`DBST_KIND_TEMP: dr_shift = {40'h0, si, v[7:1]};
			default:         dr_shift = {47'h0, si};
			endcase
		end
	endfunction

	function [15:0] next_state;
		input [15:0] s;
		input        m;
		begin
			case (s)
			S_TLR:  next_state = m ? S_TLR  : S_RTI;
			S_RTI:  next_state = m ? S_SDS  : S_RTI;
			S_SDS:  next_state = m ? S_SIS  : S_CDR;
			S_CDR:  next_state = m ? S_E1DR : S_SHDR;
			S_SHDR: next_state = m ? S_E1DR : S_SHDR;
			S_E1DR: next_state = m ? S_UDR  : S_PDR;
			S_PDR:  next_state = m ? S_E2DR : S_PDR;
			S_E2DR: next_state = m ? S_UDR  : S_SHDR;
			S_UDR:  next_state = m ? S_SDS  : S_RTI;
			S_SIS:  next_state = m ? S_TLR  : S_CIR;
			S_CIR:  next_state = m ? S_E1IR : S_SHIR;
			S_SHIR: next_state = m ? S_E1IR : S_SHIR;
			S_E1IR: next_state = m ? S_UIR  : S_PIR;
			S_PIR:  next_state = m ? S_E2IR : S_PIR;
			S_E2IR: next_state = m ? S_UIR  : S_SHIR;
			S_UIR:  next_state = m ? S_SDS  : S_RTI;
			default: next_state = S_TLR;
			endcase
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers and edge detect
	// ----------------------------------------
	reg  [2:0]  tck_sync_reg;
	reg  [1:0]  tms_sync_reg;
	reg  [1:0]  tdi_sync_reg;
	reg  [95:0] pin_s1_reg;
	reg  [95:0] pin_s2_reg;
	wire        tck_rise;
	wire        tck_fall;
	wire        tms_s;
	wire        tdi_s;

	always @(posedge core_clk) begin
		if (!reset_n) begin
			tck_sync_reg <= 3'h0;
			tms_sync_reg <= 2'h3;
			tdi_sync_reg <= 2'h3;
			pin_s1_reg   <= 96'h0;
			pin_s2_reg   <= 96'h0;
		end else begin
			tck_sync_reg <= {tck_sync_reg[1:0], tck_in};
			tms_sync_reg <= {tms_sync_reg[0], tms_in};
			tdi_sync_reg <= {tdi_sync_reg[0], tdi_in};
			pin_s1_reg   <= {pins_in_b, pins_in_a};
			pin_s2_reg   <= pin_s1_reg;
		end
	end

	assign tck_rise = tck_sync_reg[1] && !tck_sync_reg[2];
	assign tck_fall = !tck_sync_reg[1] && tck_sync_reg[2];
	assign tms_s    = tms_sync_reg[1];
	assign tdi_s    = tdi_sync_reg[1];

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	reg [15:0] state_reg;

	always @(posedge core_clk) begin
		if (!reset_n) begin
			state_reg <= S_TLR;
		end else if (tck_rise) begin
			state_reg <= next_state(state_reg, tms_s);
		end
	end

	// ----------------------------------------
	// per-channel scan registers, 0 = A, 1 = B
	// ----------------------------------------
	reg  [7:0]  ir_sh_reg  [0:1];
	reg  [7:0]  ir_reg     [0:1];
	reg  [47:0] dr_sh_reg  [0:1];
	reg  [47:0] bs_upd_reg [0:1];
	reg         link_reg;
	reg         tdo_reg;
	reg         tdo_oe_reg;
	reg         upd_pend_reg;
	wire [47:0] cap_a;
	wire [47:0] cap_b;
	wire        so_a;
	wire        so_b;
	integer     ch;

	assign cap_a = pin_s2_reg[47:0];
	// shared pins reach channel B's chain through A's pads
	assign cap_b = {pin_s2_reg[95], cap_a[`DBST_CKT_BIT],
	                cap_a[`DBST_CKC_BIT], pin_s2_reg[92:50],
	                cap_a[`DBST_RESET_BIT],
	                cap_a[`DBST_VREF_BIT]};
	assign so_a  = (state_reg == S_SHIR) ? ir_sh_reg[0][0]
	                                     : dr_sh_reg[0][0];
	assign so_b  = (state_reg == S_SHIR) ? ir_sh_reg[1][0]
	                                     : dr_sh_reg[1][0];

	always @(posedge core_clk) begin : chan_proc
		reg        si;
		reg [47:0] cap;
		si  = 1'b0;
		cap = 48'h0;
		if (!reset_n) begin
			for (ch = 0; ch < 2; ch = ch + 1) begin
				ir_sh_reg[ch]  <= 8'h00;
				ir_reg[ch]     <= `DBST_IR_IDCODE;
				dr_sh_reg[ch]  <= 48'h0;
				bs_upd_reg[ch] <= 48'h0;
			end
		end else begin
			for (ch = 0; ch < 2; ch = ch + 1) begin
				si  = (ch == 0) ? tdi_s : link_reg;
				cap = (ch == 0) ? cap_a : cap_b;
				if (tck_rise) begin
					if (state_reg == S_CIR) begin
						ir_sh_reg[ch] <= `DBST_IR_CAPTURE;
					end else if (state_reg == S_SHIR) begin
						ir_sh_reg[ch] <= {si, ir_sh_reg[ch][7:1]};
					end
					if (state_reg == S_CDR) begin
						case (dr_kind(ir_reg[ch]))
						`DBST_KIND_BS:   dr_sh_reg[ch] <= cap;
						`DBST_KIND_ID:   dr_sh_reg[ch] <= {16'h0000, ID_CODE};
						`DBST_KIND_TEMP: dr_sh_reg[ch] <= {40'h0, temp_code};
						default:         dr_sh_reg[ch] <= 48'h0;
						endcase
					end else if (state_reg == S_SHDR) begin
						dr_sh_reg[ch] <= dr_shift(dr_sh_reg[ch], si,
						                          dr_kind(ir_reg[ch]));
					end
				end
				if (state_reg == S_TLR) begin
					ir_reg[ch] <= `DBST_IR_IDCODE;
				end else if (tck_fall && state_reg == S_UIR) begin
					ir_reg[ch] <= ir_sh_reg[ch];
				end
				// clamp and high-z never reach this, so pins hold
				if (tck_fall && state_reg == S_UDR &&
				    dr_kind(ir_reg[ch]) == `DBST_KIND_BS) begin
					bs_upd_reg[ch] <= dr_sh_reg[ch];
				end
			end
		end
	end

	// ----------------------------------------
	// serial output on falling edges
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (!reset_n) begin
			link_reg   <= 1'b1;
			tdo_reg    <= 1'b1;
			tdo_oe_reg <= 1'b0;
		end else if (tck_fall) begin
			link_reg   <= so_a;
			tdo_reg    <= so_b;
			tdo_oe_reg <= (state_reg == S_SHDR) || (state_reg == S_SHIR);
		end
	end

	assign tdo_out = tdo_reg;
	assign tdo_oe  = tdo_oe_reg;

	// ----------------------------------------
	// pattern path to the pads
	// ----------------------------------------
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire [95:0] fifo_out_data;

	// a newer update while stalled simply overwrites the pending one
	always @(posedge core_clk) begin
		if (!reset_n) begin
			upd_pend_reg <= 1'b0;
		end else if (tck_fall && state_reg == S_UDR) begin
			upd_pend_reg <= 1'b1;
		end else if (fifo_in_ready) begin
			upd_pend_reg <= 1'b0;
		end
	end

	dbst_fifo #(
		.WIDTH (96),
		.DEPTH (`DBST_FIFO_DEPTH),
		.AW    (3)
	) u_fifo (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.in_valid  (upd_pend_reg),
		.in_ready  (fifo_in_ready),
		.in_data   ({bs_upd_reg[1], bs_upd_reg[0]}),
		.out_valid (fifo_out_valid),
		.out_ready (pins_ready),
		.out_data  (fifo_out_data)
	);

	// ----------------------------------------
	// pad control per channel
	// ----------------------------------------
	reg [47:0] pat_reg     [0:1];
	reg [1:0]  own_reg;
	reg [1:0]  low_oe_reg;
	reg [1:0]  high_oe_reg;
	reg [1:0]  chan_rst_reg;
	integer    pc;
	always @(posedge core_clk) begin
		if (!reset_n) begin
			pat_reg[0]   <= 48'h0;
			pat_reg[1]   <= 48'h0;
			own_reg      <= 2'h0;
			low_oe_reg   <= 2'h0;
			high_oe_reg  <= 2'h0;
			chan_rst_reg <= 2'h0;
		end else begin
			if (fifo_out_valid && pins_ready) begin
				pat_reg[0] <= fifo_out_data[47:0];
				pat_reg[1] <= fifo_out_data[95:48];
			end
			for (pc = 0; pc < 2; pc = pc + 1) begin
				// takes the pads as soon as the code is in force
				own_reg[pc]      <= restrictive(ir_reg[pc]);
				chan_rst_reg[pc] <= restrictive(ir_reg[pc]);
				low_oe_reg[pc]   <= restrictive(ir_reg[pc]) &&
				                    ir_reg[pc] != `DBST_IR_HIGHZ &&
				                    pat_reg[pc][`DBST_OE_LOW_BIT];
				high_oe_reg[pc]  <= restrictive(ir_reg[pc]) &&
				                    ir_reg[pc] != `DBST_IR_HIGHZ &&
				                    pat_reg[pc][`DBST_OE_HIGH_BIT];
			end
		end
	end

	assign scan_pattern_a = pat_reg[0];
	assign scan_pattern_b = pat_reg[1];
	assign scan_own_a     = own_reg[0];
	assign scan_own_b     = own_reg[1];
	assign scan_low_oe_a  = low_oe_reg[0];
	assign scan_low_oe_b  = low_oe_reg[1];
	assign scan_high_oe_a = high_oe_reg[0];
	assign scan_high_oe_b = high_oe_reg[1];
	assign chan_reset_a   = chan_rst_reg[0];
	assign chan_reset_b   = chan_rst_reg[1];

endmodule // dbst_tap

// >>> bench/dbst_asserts.sv
module dbst_asserts (
	// clock and reset
	input wire        core_clk,
	input wire        reset_n,
	// test port
	input wire        tck_in,
	input wire        tms_in,
	input wire        tdo_out,
	input wire        tdo_oe,
	// pattern delivery and channel control
	input wire        pins_ready,
	input wire [47:0] scan_pattern_a,
	input wire        scan_own_a,
	input wire        scan_own_b,
	input wire        scan_low_oe_a,
	input wire        scan_high_oe_a,
	input wire        chan_reset_a,
	input wire        chan_reset_b
);
	// ----------------------------------------
	// test clock history
	// ----------------------------------------
	logic [2:0] lo_cnt;
	logic [2:0] hi_cnt;
	logic       tck_q;

	always @(posedge core_clk) begin
		if (!reset_n) begin
			lo_cnt <= 3'h0;
			hi_cnt <= 3'h0;
			tck_q  <= 1'b0;
		end else begin
			tck_q  <= tck_in;
			lo_cnt <= tck_in ? 3'h0 : (lo_cnt == 3'h7 ? 3'h7 : lo_cnt + 3'h1);
			if (!tms_in)
				hi_cnt <= 3'h0;
			else if (tck_in && !tck_q && hi_cnt != 3'h7)
				hi_cnt <= hi_cnt + 3'h1;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence tms_five_s;
		hi_cnt == 3'h5;
	endsequence
	sequence released_s;
		##[0:8] (!scan_own_a && !scan_own_b);
	endsequence

	tdo_edge_a: assert property (
		$changed(tdo_out) |-> lo_cnt inside {[3'h2:3'h5]})
		else $error("serial output moved away from a clock fall");
	drive_edge_a: assert property (
		$changed(tdo_oe) |-> lo_cnt inside {[3'h2:3'h5]})
		else $error("output enable moved away from a clock fall");
	own_reset_a: assert property (
		scan_own_a == chan_reset_a && scan_own_b == chan_reset_b)
		else $error("channel reset disagrees with pin ownership");
	oe_owned_a: assert property (
		scan_low_oe_a |-> scan_own_a || $past(scan_own_a))
		else $error("byte enable without pin ownership");
	low_oe_bit_a: assert property (
		$rose(scan_low_oe_a) |->
			$past(scan_pattern_a[15]) || $past(scan_pattern_a[15], 2))
		else $error("low byte enable without cell 15 set");
	high_oe_bit_a: assert property (
		$rose(scan_high_oe_a) |->
			$past(scan_pattern_a[32]) || $past(scan_pattern_a[32], 2))
		else $error("high byte enable without cell 32 set");
	pattern_ready_a: assert property (
		$changed(scan_pattern_a) |-> $past(pins_ready) || $past(pins_ready, 2))
		else $error("pattern changed while the pad ring stalled");
	port_reset_a: assert property (
		tms_five_s |-> released_s)
		else $error("pins still owned after five high mode bits");
endmodule // dbst_asserts

// >>> bench/dbst_tester.sv
module dbst_tester (
	// test port pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input  wire  tdo,
	input  wire  tdo_en
);
	timeunit 1ns;
	timeprecision 1ns;

	logic q_last;

	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		q_last = 1'b0;
	end

	// ----------------------------------------
	// one test clock, output taken before the rise
	// ----------------------------------------
	task automatic tbit(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#40;
		q = tdo_en ? tdo : ~q_last;
		q_last = q;
		tck = 1'b1;
		#40;
		tck = 1'b0;
	endtask

	task automatic tlr();
		logic q;
		repeat (5) tbit(1'b1, 1'b1, q);
		tbit(1'b0, 1'b1, q);
	endtask

	// idle to idle; channel B code first, bit 0 first
	task automatic scan(input logic ir, input int n,
		input logic [95:0] din, output logic [95:0] dout);
		logic q;
		dout = '0;
		tbit(1'b1, 1'b1, q);
		if (ir)
			tbit(1'b1, 1'b1, q);
		tbit(1'b0, 1'b1, q);
		tbit(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			tbit(i == n - 1, din[i], dout[i]);
		end
		tbit(1'b1, 1'b1, q);
		tbit(1'b0, 1'b1, q);
	endtask
endmodule // dbst_tester

// >>> bench/tb_dram_boundary_scan_tap.sv
module tb_dram_boundary_scan_tap;
	timeunit 1ns;
	timeprecision 1ns;

	// arbitrary identification value, bit 0 set
	localparam logic [31:0] ID = 32'h00a5_5a01;
	localparam logic [47:0] PA = 48'h00f0_3c3c_f0f0;
	localparam logic [47:0] PB = 48'h0f01_00ff_0f0f;
	// ignored cells: error pin 19 on A, 29 on B, cell 8 on both
	localparam logic [47:0] IGN_A = 48'hffff_fff7_feff;
	localparam logic [47:0] IGN_B = 48'hffff_dfff_feff;

	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        pins_ready = 1'b1;
	logic        tck, tms, tdi, tdo_out, tdo_oe;
	logic [47:0] pins_a = 48'h0123_4567_89ab;
	logic [47:0] pins_b = 48'hfedc_ba98_7654;
	logic [7:0]  temp = 8'hc3;
	logic [47:0] pat_a, pat_b;
	logic        own_a, own_b, crst_a, crst_b, loe_a, loe_b, hoe_a, hoe_b;
	logic [95:0] q;
	logic [7:0]  byp [3] = '{8'h00, 8'hff, 8'h5a};
	int          errors = 0;
	int          n_compared = 0;

	always #4 core_clk = ~core_clk;

	dbst_tap #(.ID_CODE(ID)) dut_u (
		.core_clk(core_clk), .reset_n(reset_n), .tck_in(tck), .tms_in(tms),
		.tdi_in(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
		.pins_in_a(pins_a), .pins_in_b(pins_b), .temp_code(temp),
		.pins_ready(pins_ready), .scan_pattern_a(pat_a),
		.scan_pattern_b(pat_b), .scan_own_a(own_a), .scan_own_b(own_b),
		.scan_low_oe_a(loe_a), .scan_low_oe_b(loe_b),
		.scan_high_oe_a(hoe_a), .scan_high_oe_b(hoe_b),
		.chan_reset_a(crst_a), .chan_reset_b(crst_b));

	dbst_tester tst_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_out),
		.tdo_en(tdo_oe));

	// ----------------------------------------
	// checks and closing
	// ----------------------------------------
	task automatic end_of_test();
		$display("compared %0d, mismatched %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cmp_scan(input logic [95:0] got, exp, input string what);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h", $time, what, got);
		end
	endtask

	task automatic cmp_pins(input logic [7:0] exp, input string what);
		cmp_scan({own_a, own_b, crst_a, crst_b, loe_a, hoe_a, loe_b, hoe_b},
			exp, what);
	endtask

	task automatic wait_pat(input logic [47:0] ea);
		int k;
		k = 0;
		while (pat_a !== ea && k < 60) begin
			@(negedge core_clk);
			k++;
		end
		if (pat_a !== ea) begin
			errors++;
			$display("unexpected at %0t: pattern never arrived", $time);
			end_of_test();
		end
	endtask

	// ----------------------------------------
	// sequence of tests
	// ----------------------------------------
	initial begin
		repeat (10) @(negedge core_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge core_clk);
		cmp_scan({tdo_out, tdo_oe}, 2'b10, "reset tdo");
		cmp_pins(8'h00, "reset pins");
		$display("done: reset");
		tst_u.tlr();
		tst_u.scan(0, 64, '0, q);
		cmp_scan(q[63:0], {ID, ID}, "idcode");
		$display("done: idcode");
		foreach (byp[i]) begin
			tst_u.scan(1, 16, {byp[i], byp[i]}, q);
			cmp_scan(q[15:0], 16'h0101, "ir capture");
			tst_u.scan(0, 4, 4'hd, q);
			cmp_scan(q[3:0], 4'h4, "bypass");
			cmp_pins(8'h00, "bypass pins");
		end
		$display("done: bypass");
		tst_u.scan(1, 16, 16'h2020, q);
		tst_u.scan(0, 16, '0, q);
		cmp_scan(q[15:0], 16'hc3c3, "temperature");
		cmp_pins(8'h00, "temperature pins");
		$display("done: temperature");
		tst_u.scan(1, 16, 16'h0101, q);
		@(negedge core_clk);
		pins_ready = 1'b0;
		tst_u.scan(0, 96, {PA, PB}, q); // snapshot discarded
		cmp_scan({pat_a, pat_b}, 96'h0, "stalled pattern");
		@(negedge core_clk);
		pins_ready = 1'b1;
		wait_pat(PA);
		cmp_scan({pat_a, pat_b}, {PA, PB}, "preload");
		cmp_pins(8'h00, "preload pins");
		$display("done: preload");
		tst_u.scan(1, 16, 16'h1008, q);
		cmp_scan({pat_a, pat_b}, {PA, PB}, "extest pattern");
		cmp_pins(8'hf8, "extest pins");
		tst_u.scan(0, 49, {~PA, 1'b1}, q);
		wait_pat(~PA);
		cmp_scan(q[48:0] & {IGN_A, 1'b1}, {pins_a & IGN_A, 1'b0},
			"extest capture");
		cmp_scan({pat_a, pat_b}, {~PA, PB}, "extest update");
		cmp_pins(8'hf4, "extest update pins");
		$display("done: extest");
		tst_u.scan(1, 16, 16'h0404, q);
		tst_u.scan(0, 2, 2'h3, q);
		cmp_scan(q[1:0], 2'h0, "clamp bypass");
		cmp_scan({pat_a, pat_b}, {~PA, PB}, "clamp pattern");
		cmp_pins(8'hf5, "clamp pins");
		$display("done: clamp");
		tst_u.scan(1, 16, 16'h1010, q);
		tst_u.scan(0, 96, {PB, PA}, q);
		wait_pat(PB);
		cmp_scan(q & {IGN_A, IGN_B}, {pins_a & IGN_A, IGN_B &
			{pins_b[47], pins_a[46:45], pins_b[44:2], pins_a[1:0]}},
			"capture");
		cmp_scan({pat_a, pat_b}, {PB, PA}, "extest both");
		cmp_pins(8'hf6, "extest both pins");
		$display("done: extest both");
		tst_u.tlr();
		cmp_pins(8'h00, "port reset pins");
		tst_u.scan(0, 64, '0, q);
		cmp_scan(q[63:0], {ID, ID}, "port reset idcode");
		$display("done: port reset");
		end_of_test();
	end
endmodule // tb_dram_boundary_scan_tap

bind dbst_tap dbst_asserts chk_u (.core_clk(core_clk), .reset_n(reset_n),
	.tck_in(tck_in), .tms_in(tms_in), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
	.pins_ready(pins_ready), .scan_pattern_a(scan_pattern_a),
	.scan_own_a(scan_own_a), .scan_own_b(scan_own_b),
	.scan_low_oe_a(scan_low_oe_a), .scan_high_oe_a(scan_high_oe_a),
	.chan_reset_a(chan_reset_a), .chan_reset_b(chan_reset_b));
